// ==== hw/lpas_top.sv ====
// per-channel alarm status bytes of a twelve-channel line receiver
// Contract
// (R1) Bit 6 of each status byte reads 1 while the pattern checker has lost lock, else 0.
// (R2) The pattern checker declares loss of lock after a very large number of bit errors.
// (R3) The pattern checker regains lock on seeing its pattern with few or no bit errors.
// (R4) Software trusts bit 6 only with generator, checker and line loopback all in place.
// (R5) In DS3/STS-1, digital loss of signal is declared after 160 bit periods without pulses.
// (R6) In DS3/STS-1, digital loss of signal clears once pulse density reaches 33%.
// (R7) Bit 5 reads 1 while the digital detector declares a defect, else 0.
// (R8) In DS3/STS-1, the analog detector declares a defect when amplitude drops too low.
// (R9) In DS3/STS-1, the analog detector clears only above a higher threshold (hysteresis).
// (R10) Bit 4 reads 1 while the analog detector declares a defect, else 0.
// (R11) Bit 1 is the channel's loss of signal, the OR of the analog and digital defects.
// (R12) The status bits are read-only and host writes leave them unchanged.
// (R13) Each of twelve channels has its own byte at address m3, m being 0-5 or 8-D.
// (R14) A per-channel change-of-LOS bit latches on any change and clears when read.
// (R15) In E3, the channel's loss of signal follows the G.775 detector instead.
// (R16) Bit 7 is reserved, reads zero and ignores writes.
`timescale 1ns/1ps
`include "lpas_map.svh"
module lpas_top
    import lpas_pkg::*;
(
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_b,
    // microprocessor port
    input wire logic up_cs_b,
    input wire logic up_rd_b,
    input wire logic [7:0] up_addr,
    output logic [7:0] up_rdata,
    output logic up_rdata_oe,
    // receive line, one bit per channel
    input wire logic [11:0] rx_rclk,
    input wire logic [11:0] rx_data,
    // analog and G.775 detector results, one bit per channel
    input wire logic [11:0] alos_in,
    input wire logic [11:0] g775_los_in,
    // channel configuration
    input wire logic [11:0] e3_mode,
    input wire logic [11:0] prbs_rx_en
);

    lpas_top_st_t q;
    lpas_top_st_t d;
    lpas_pins_t pins;
    logic [11:0] bit_tick;
    logic [11:0] dlos_v;
    logic [11:0] prbs_v;
    logic [11:0] los_calc;
    logic rd_act;
    logic rd_start;
    logic [4:0] dec;
    logic [3:0] ch_idx;
    logic hit_stat;
    logic hit_src;
    logic [7:0] stat_byte;
    logic [7:0] src_byte;

    // map the upper address nibble onto a channel; bit 4 flags a valid nibble
    function automatic logic [4:0] lpas_decode(input logic [3:0] m);
        logic [4:0] r;
        r = 5'h00;
        if (m < 4'h6)
            r = {1'b1, m};
        else if (m >= 4'h8 && m <= 4'hd)
            r = {1'b1, m - 4'h2};
        return r;
    endfunction

    // pins gathered active high before the synchroniser
    always_comb
    begin
        pins.sel = ~up_cs_b;
        pins.rd = ~up_rd_b;
        pins.addr = up_addr;
        pins.rclk = rx_rclk;
        pins.data = rx_data;
        pins.alos = alos_in;
        pins.g775 = g775_los_in;
        pins.e3 = e3_mode;
        pins.prbs_en = prbs_rx_en;
    end

    // recovered clock is sampled, so it must stay well below half of core_clk
    assign bit_tick = q.s2.rclk & ~q.rclk_d;

    // one detector instance per channel
    for (genvar g = 0; g < 12; g++)
    begin : g_chan
        lpas_chan_if cif();
        assign cif.bit_tick = bit_tick[g];
        assign cif.bit_data = q.s2.data[g];
        assign cif.prbs_en = q.s2.prbs_en[g];
        assign dlos_v[g] = cif.dlos;
        assign prbs_v[g] = cif.prbs_loss;
        lpas_chan u_chan (
            .core_clk (core_clk),
            .rst_b (rst_b),
            .lnk (cif)
        );
    end

    // the analog comparator carries its own hysteresis, so its level is taken as is
    // and E3 channels take the G.775 result in place of the OR
    assign los_calc = (q.s2.e3 & q.s2.g775) | (~q.s2.e3 & (q.s2.alos | dlos_v)); // R8 R9 R11 R15

    // read strobe on the synchronised leading edge of select and read together
    assign rd_act = q.s2.sel & q.s2.rd;
    assign rd_start = rd_act & ~q.rd_d;

    // address decode
    assign dec = lpas_decode(q.s2.addr[7:4]); // R13
    assign ch_idx = dec[3:0];
    assign hit_stat = dec[4] && q.s2.addr[3:0] == `LPAS_OFS_STATUS; // R13
    assign hit_src = dec[4] && q.s2.addr[3:0] == `LPAS_OFS_INTSRC;

    // status and interrupt source bytes; unfilled bits, bit 7 among them, stay zero
    always_comb
    begin
        stat_byte = 8'h00; // R16
        src_byte = 8'h00;
        stat_byte[`LPAS_BIT_PRBS] = prbs_v[ch_idx]; // R1
        stat_byte[`LPAS_BIT_DLOS] = dlos_v[ch_idx]; // R7
        stat_byte[`LPAS_BIT_ALOS] = q.s2.alos[ch_idx]; // R10
        stat_byte[`LPAS_BIT_LOS] = q.los[ch_idx]; // R11
        src_byte[`LPAS_BIT_COS_LOS] = q.cos[ch_idx];
    end

    // next state; the port has no write path, so nothing here can be overwritten
    always_comb
    begin
        d = q;
        d.s1 = pins;
        d.s2 = q.s1;
        d.rclk_d = q.s2.rclk;
        d.rd_d = rd_act;
        d.oe = rd_act;
        d.los = los_calc;
        // change latch: a change in the read cycle survives the clear
        d.cos = q.cos;
        if (rd_start && hit_src)
            d.cos[ch_idx] = 1'b0; // R14
        d.cos = d.cos | (los_calc ^ q.los); // R14
        // read data captured once per access and held until the next
        if (rd_start)
        begin
            if (hit_stat)
                d.rdata = stat_byte; // R12
            else if (hit_src)
                d.rdata = src_byte;
            else
                d.rdata = 8'h00;
        end
    end

    // state register
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
            q <= '0;
        else
            q <= d;
    end

    // ports come from flops
    assign up_rdata = q.rdata;
    assign up_rdata_oe = q.oe;

    AST_PRBS_BIT: assert property (@(posedge core_clk) disable iff (!rst_b) // R1
        rd_start && hit_stat |=> up_rdata[6] == $past(prbs_v[ch_idx]))
        else $error("status bit 6 does not follow pattern loss");

    AST_DLOS_BIT: assert property (@(posedge core_clk) disable iff (!rst_b) // R7
        rd_start && hit_stat |=> up_rdata[5] == $past(dlos_v[ch_idx]))
        else $error("status bit 5 does not follow digital los");

    AST_ALOS_BIT: assert property (@(posedge core_clk) disable iff (!rst_b) // R10
        rd_start && hit_stat |=> up_rdata[4] == 1'($past(alos_in, 3) >> $past(ch_idx)))
        else $error("status bit 4 does not follow the analog pin");

    AST_LOS_OR: assert property (@(posedge core_clk) disable iff (!rst_b) // R11
        ##1 !$past(q.s2.e3[0]) |-> q.los[0] == ($past(q.s2.alos[0]) | $past(dlos_v[0])))
        else $error("channel los is not the or of both detectors");

    AST_LOS_E3: assert property (@(posedge core_clk) disable iff (!rst_b) // R15
        q.s2.e3[0] |=> q.los[0] == $past(q.s2.g775[0]))
        else $error("e3 channel los does not follow g775 detector");

    AST_COS_SET: assert property (@(posedge core_clk) disable iff (!rst_b) // R14
        $changed(q.los) |-> ((q.los ^ $past(q.los)) & ~q.cos) == 12'h000)
        else $error("los change not latched");

    AST_COS_CLR: assert property (@(posedge core_clk) disable iff (!rst_b) // R14
        rd_start && hit_src && los_calc[ch_idx] == q.los[ch_idx] |=> !q.cos[$past(ch_idx)])
        else $error("change bit not cleared by its read");

    AST_RSVD: assert property (@(posedge core_clk) disable iff (!rst_b) // R16
        up_rdata_oe |-> !up_rdata[7])
        else $error("reserved bit 7 reads one");

    AST_DECODE: assert property (@(posedge core_clk) disable iff (!rst_b) // R13
        rd_start && !hit_stat && !hit_src |=> up_rdata == 8'h00 ##1 up_rdata == 8'h00)
        else $error("unmapped address returned data");

    AST_LOS_BIT: assert property (@(posedge core_clk) disable iff (!rst_b) // R11
        rd_start && hit_stat |=> up_rdata[1] == $past(q.los[ch_idx]))
        else $error("status bit 1 does not follow channel los");

    AST_E3_ALL: assert property (@(posedge core_clk) disable iff (!rst_b) // R15
        1'b1 |=> (q.los & $past(q.s2.e3)) == ($past(q.s2.g775) & $past(q.s2.e3)))
        else $error("an e3 channel los does not follow its g775 detector");

    // the change byte returns the latch as it was before the clearing read
    AST_COS_READ: assert property (@(posedge core_clk) disable iff (!rst_b) // R14
        rd_start && hit_src |=> up_rdata[1] == $past(q.cos[ch_idx]) && up_rdata[7:2] == 6'h00)
        else $error("change byte does not return the latch");

    // no host access but a read capture may alter the byte on the port
    AST_RDATA_HOLD: assert property (@(posedge core_clk) disable iff (!rst_b) // R12
        !rd_start |=> $stable(up_rdata))
        else $error("read byte moved without a read");

endmodule

// ==== include/lpas_map.svh ====
// offsets, bit positions, reset values and counts of the alarm status block
`ifndef LPAS_MAP_SVH
`define LPAS_MAP_SVH

// low address nibble of the per-channel registers
`define LPAS_OFS_STATUS 4'h3
`define LPAS_OFS_INTSRC 4'h2

// status byte field positions
`define LPAS_BIT_RSVD 3'h7
`define LPAS_BIT_PRBS 3'h6
`define LPAS_BIT_DLOS 3'h5
`define LPAS_BIT_ALOS 3'h4
`define LPAS_BIT_LOS 3'h1

// interrupt source byte field position
`define LPAS_BIT_COS_LOS 3'h1

// reset values
`define LPAS_RST_DLOS 1'h0
`define LPAS_RST_PRBS_LOSS 1'h1

// digital detector: 160 zero bits declare, 10 ones in 30 bits (33%) clear
`define LPAS_DLOS_ZEROS 8'ha0
`define LPAS_DENS_WIN 5'h1e
`define LPAS_DENS_ONES 5'h0a

// pattern checker: 64-bit window, 16 errors lose, at most 1 error locks
`define LPAS_PRBS_LAST 6'h3f
`define LPAS_PRBS_LOSE 7'h10
`define LPAS_PRBS_LOCK 7'h01

`endif

// ==== include/lpas_pkg.sv ====
// types shared by the alarm status block
package lpas_pkg;

    // pins after inversion to active high, the twelve-bit fields one bit per channel
    typedef struct packed {
        logic sel;
        logic rd;
        logic [7:0] addr;
        logic [11:0] rclk;
        logic [11:0] data;
        logic [11:0] alos;
        logic [11:0] g775;
        logic [11:0] e3;
        logic [11:0] prbs_en;
    } lpas_pins_t;

    // top level state
    typedef struct packed {
        lpas_pins_t s1;
        lpas_pins_t s2;
        logic [11:0] rclk_d;
        logic rd_d;
        logic [11:0] los;
        logic [11:0] cos;
        logic [7:0] rdata;
        logic oe;
    } lpas_top_st_t;

    // per-channel detector state
    typedef struct packed {
        logic [7:0] zrun;
        logic [4:0] win_cnt;
        logic [4:0] ones;
        logic dlos;
        logic [14:0] prbs_hist;
        logic [5:0] prbs_bit;
        logic [6:0] prbs_err;
        logic prbs_loss;
    } lpas_chan_st_t;

endpackage

// ==== include/lpas_chan_if.sv ====
// link between the register logic and one channel's detectors
`timescale 1ns/1ps
interface lpas_chan_if;
    logic bit_tick;
    logic bit_data;
    logic prbs_en;
    logic dlos;
    logic prbs_loss;

    modport chan (input bit_tick, input bit_data, input prbs_en, output dlos, output prbs_loss);
    modport host (output bit_tick, output bit_data, output prbs_en, input dlos, input prbs_loss);
endinterface

// ==== hw/lpas_chan.sv ====
// digital loss-of-signal detector and pattern lock checker of one channel
`timescale 1ns/1ps
`include "lpas_map.svh"
module lpas_chan
    import lpas_pkg::*;
(
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_b,
    // bit stream in, defects out
    lpas_chan_if.chan lnk
);

    lpas_chan_st_t q;
    lpas_chan_st_t d;
    logic pred;
    logic [6:0] perr_n;
    logic [4:0] ones_n;

    // outputs straight from state
    assign lnk.dlos = q.dlos;
    assign lnk.prbs_loss = q.prbs_loss;

    // next state, advanced only on a recovered bit except the checker disable, which acts on every cycle
    always_comb
    begin
        d = q;
        pred = q.prbs_hist[14] ^ q.prbs_hist[13];
        perr_n = q.prbs_err + {6'h00, lnk.bit_data != pred};
        ones_n = q.ones + {4'h0, lnk.bit_data};
        if (lnk.bit_tick)
        begin
            // run of zeros, saturating so a long outage cannot wrap
            if (lnk.bit_data)
                d.zrun = 8'h00;
            else if (q.zrun != `LPAS_DLOS_ZEROS)
                d.zrun = q.zrun + 8'h01;
            // density window; clearing only at a window end
            if (q.win_cnt == `LPAS_DENS_WIN - 5'h01)
            begin
                d.win_cnt = 5'h00;
                d.ones = 5'h00;
                if (ones_n >= `LPAS_DENS_ONES)
                    d.dlos = 1'b0; // R6
            end
            else
            begin
                d.win_cnt = q.win_cnt + 5'h01;
                d.ones = ones_n;
            end
            // declaring after clearing so the declare wins a tie
            if (!lnk.bit_data && q.zrun == `LPAS_DLOS_ZEROS - 8'h01)
                d.dlos = 1'b1; // R5
            // self-synchronising checker of x^15+x^14+1
            d.prbs_hist = {q.prbs_hist[13:0], lnk.bit_data};
            if (q.prbs_bit == `LPAS_PRBS_LAST)
            begin
                d.prbs_bit = 6'h00;
                d.prbs_err = 7'h00;
                if (perr_n >= `LPAS_PRBS_LOSE)
                    d.prbs_loss = 1'b1; // R2
                else if (perr_n <= `LPAS_PRBS_LOCK)
                    d.prbs_loss = 1'b0; // R3
            end
            else
            begin
                d.prbs_bit = q.prbs_bit + 6'h01;
                d.prbs_err = perr_n;
            end
        end
        // a disabled checker reports loss and restarts its window
        if (!lnk.prbs_en)
        begin
            d.prbs_bit = 6'h00;
            d.prbs_err = 7'h00;
            d.prbs_loss = 1'b1;
        end
    end

    // state register
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            q <= '0;
            q.dlos <= `LPAS_RST_DLOS;
            q.prbs_loss <= `LPAS_RST_PRBS_LOSS;
        end
        else
            q <= d;
    end

    AST_DLOS_SET: assert property (@(posedge core_clk) disable iff (!rst_b) // R5
        lnk.bit_tick && !lnk.bit_data && q.zrun == 8'h9f |=> lnk.dlos)
        else $error("digital los not declared after 160 zero bits");

    AST_DLOS_CLR: assert property (@(posedge core_clk) disable iff (!rst_b) // R6
        $fell(lnk.dlos) |-> $past(lnk.bit_tick && q.win_cnt == 5'h1d && ones_n >= 5'h0a))
        else $error("digital los cleared without enough pulse density");

    AST_DLOS_HOLD: assert property (@(posedge core_clk) disable iff (!rst_b) // R7
        !lnk.bit_tick |=> $stable(lnk.dlos))
        else $error("digital los moved without a recovered bit");

    AST_PRBS_LOSE: assert property (@(posedge core_clk) disable iff (!rst_b) // R2
        lnk.bit_tick && q.prbs_bit == 6'h3f && perr_n >= 7'h10 |=> lnk.prbs_loss)
        else $error("pattern loss not declared on heavy errors");

    AST_PRBS_LOCK: assert property (@(posedge core_clk) disable iff (!rst_b) // R3
        $fell(lnk.prbs_loss) |-> $past(lnk.prbs_en && q.prbs_bit == 6'h3f && perr_n <= 7'h01))
        else $error("pattern lock declared without a clean window");

endmodule

// ==== verif/lpas_line_src.sv ====
// line-side stream source standing in for the looped-back receive signal
`timescale 1ns/1ps
module lpas_line_src
(
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_b,
    // pattern: 0 zeros, 1 ones, 2 prbs, 3 one in three, 4 one in four
    input wire logic [2:0] mode,
    // recovered clock and data, same on every channel
    output logic [11:0] rclk,
    output logic [11:0] data
);
    logic [2:0] cnt_q;
    logic [3:0] ph_q;
    logic [14:0] lfsr_q;
    logic fb;
    logic bit_v;

    // next bit of the selected pattern
    always_comb
    begin
        fb = lfsr_q[14] ^ lfsr_q[13];
        case (mode)
            3'h1: bit_v = 1'h1;
            3'h2: bit_v = fb;
            3'h3: bit_v = (ph_q == 4'h0) || (ph_q == 4'h3) || (ph_q == 4'h6) || (ph_q == 4'h9);
            3'h4: bit_v = (ph_q[1:0] == 2'h0);
            default: bit_v = 1'h0;
        endcase
    end

    // eight core cycles a bit; data moves in the last cycle of the high phase, three cycles after the rise
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            cnt_q <= 3'h0;
            ph_q <= 4'h0;
            lfsr_q <= 15'h0001;
            rclk <= 12'h000;
            data <= 12'h000;
        end
        else
        begin
            cnt_q <= cnt_q + 3'h1;
            rclk <= {12{cnt_q[2]}};
            if (cnt_q == 3'h7)
            begin
                data <= {12{bit_v}};
                lfsr_q <= {lfsr_q[13:0], fb};
                ph_q <= (ph_q == 4'hb) ? 4'h0 : ph_q + 4'h1;
            end
        end
    end
endmodule

// ==== verif/testbench.sv ====
// self-checking bench of the alarm status block
`timescale 1ns/1ps
module testbench;
    logic core_clk = 1'b0;
    logic rst_b = 1'b0;
    logic up_cs_b = 1'b1;
    logic up_rd_b = 1'b1;
    logic [7:0] up_addr = 8'h00;
    logic [7:0] up_rdata;
    logic up_rdata_oe;
    logic [11:0] rx_rclk;
    logic [11:0] rx_data;
    logic [11:0] alos_in = 12'h000;
    logic [11:0] g775_los_in = 12'h000;
    logic [11:0] e3_mode = 12'h000;
    logic [11:0] prbs_rx_en = 12'h000;
    logic [2:0] mode = 3'h1;
    logic [7:0] exp_v;
    int err_total = 0;
    int checks_done = 0;

    // 10 MHz core clock
    always #50 core_clk = ~core_clk;

    lpas_top u_dut (.core_clk(core_clk), .rst_b(rst_b), .up_cs_b(up_cs_b), .up_rd_b(up_rd_b),
        .up_addr(up_addr), .up_rdata(up_rdata), .up_rdata_oe(up_rdata_oe), .rx_rclk(rx_rclk),
        .rx_data(rx_data), .alos_in(alos_in), .g775_los_in(g775_los_in), .e3_mode(e3_mode),
        .prbs_rx_en(prbs_rx_en));

    lpas_line_src u_src (.core_clk(core_clk), .rst_b(rst_b), .mode(mode), .rclk(rx_rclk),
        .data(rx_data));

    // verdict in one place for both the normal end and the watchdog
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        checks_done++;
        if (g !== e)
        begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask

    // one strobe held until the enable is seen, then released for four cycles
    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        int n;
        n = 0;
        @(posedge core_clk);
        up_cs_b <= 1'b0;
        up_rd_b <= 1'b0;
        up_addr <= a;
        do
        begin
            @(posedge core_clk);
            #1;
            n++;
        end
        while (up_rdata_oe !== 1'b1 && n < 20);
        v = up_rdata;
        if (n >= 20)
            chk("read enable", 8'h01, 8'h00);
        @(posedge core_clk);
        up_cs_b <= 1'b1;
        up_rd_b <= 1'b1;
        repeat (4) @(posedge core_clk);
    endtask

    task automatic rchk(input string nm, input logic [7:0] a, input logic [7:0] e);
        logic [7:0] v;
        rd(a, v);
        chk(nm, e, v);
    endtask

    task automatic bits(input int n);
        repeat (n * 8) @(posedge core_clk);
    endtask

    function automatic logic [7:0] st_addr(input int ch);
        return {(ch < 6) ? ch[3:0] : ch[3:0] + 4'h2, 4'h3};
    endfunction

    // hang guard, about three times the expected run
    initial
    begin
        repeat (25000) @(posedge core_clk);
        err_total++;
        tally_and_finish();
    end

    initial
    begin
        repeat (5) @(posedge core_clk);
        rst_b <= 1'b1;
        bits(40);
        rchk("status after reset", 8'h03, 8'h40);
        rchk("change bit after reset", 8'h02, 8'h00);
        $display("test reset done");

        alos_in <= 12'h5a5;
        repeat (8) @(posedge core_clk);
        rchk("analog loss ch0", 8'h03, 8'h52);
        for (int c = 0; c < 12; c++)
        begin
            exp_v = alos_in[c] ? 8'h52 : 8'h40;
            rchk("status per channel", st_addr(c), exp_v);
        end
        rchk("unmapped m6", 8'h63, 8'h00);
        rchk("unmapped mf", 8'hf3, 8'h00);
        rchk("unmapped low nibble", 8'h05, 8'h00);
        e3_mode <= 12'h003;
        g775_los_in <= 12'h001;
        alos_in <= 12'h002;
        repeat (8) @(posedge core_clk);
        rchk("e3 follows g775", 8'h03, 8'h42);
        rchk("e3 analog bit", 8'h13, 8'h50);
        e3_mode <= 12'h000;
        g775_los_in <= 12'h000;
        alos_in <= 12'h000;
        repeat (8) @(posedge core_clk);
        rchk("analog clear ch1", 8'h13, 8'h40);
        rchk("change bit after map", 8'h02, 8'h02);
        $display("test map done");

        mode <= 3'h0;
        bits(150);
        rchk("no loss before 160 zeros", 8'h03, 8'h40);
        bits(15);
        rchk("digital loss declared", 8'h03, 8'h62);
        rchk("digital loss ch11", 8'hd3, 8'h62);
        rchk("change of loss set", 8'h02, 8'h02);
        rchk("change of loss cleared", 8'h02, 8'h00);
        @(posedge core_clk);
        up_cs_b <= 1'b0;
        repeat (6) @(posedge core_clk);
        up_cs_b <= 1'b1;
        repeat (4) @(posedge core_clk);
        rchk("status unchanged by access", 8'h03, 8'h62);
        mode <= 3'h4;
        bits(90);
        rchk("density 25 holds loss", 8'h03, 8'h62);
        mode <= 3'h3;
        bits(70);
        rchk("density 33 clears loss", 8'h03, 8'h40);
        $display("test digital done");

        prbs_rx_en <= 12'hfff;
        mode <= 3'h2;
        bits(200);
        rchk("pattern locked", 8'h03, 8'h00);
        rchk("pattern locked ch11", 8'hd3, 8'h00);
        mode <= 3'h1;
        bits(150);
        rchk("pattern lost on errors", 8'h03, 8'h40);
        mode <= 3'h2;
        bits(200);
        rchk("pattern relocked", 8'h03, 8'h00);
        prbs_rx_en <= 12'h000;
        repeat (10) @(posedge core_clk);
        rchk("checker off reads loss", 8'h03, 8'h40);
        $display("test pattern done");
        tally_and_finish();
    end
endmodule
